// *** rtl/litc_pkg.sv ***
// Purpose: constants for the legacy I/O trap capture block
// Assumes: 16-bit host I/O addresses, 32-bit control/status word
// Notes:   offsets, field positions, reset values and decode windows
package litc_pkg;
   // register offset on the register access port (regAddr)
   localparam logic [5:0]  LITC_OFS_CTRL_STAT = 6'h18;
   // control field positions
   localparam int          LITC_B_FAST   = 31;
   localparam int          LITC_B_HIB    = 30;
   localparam int          LITC_B_SNDSEL = 29;
   localparam int          LITC_B_BASEHI = 28;
   localparam int          LITC_B_BASELO = 27;
   localparam int          LITC_B_CDCHI  = 26;
   localparam int          LITC_B_CDCLO  = 25;
   localparam int          LITC_B_FORCE  = 24;
   localparam int          LITC_B_SDMA   = 23;
   localparam int          LITC_B_SINTC  = 22;
   localparam int          LITC_B_MDMA   = 21;
   localparam int          LITC_B_MINTC  = 20;
   localparam int          LITC_B_FM     = 19;
   localparam int          LITC_B_SND    = 18;
   localparam int          LITC_B_CDC    = 17;
   localparam int          LITC_B_BASE   = 16;
   // reset values
   localparam logic [15:0] LITC_CTRL_RST  = 16'h0000;
   localparam logic [4:0]  LITC_ONES      = 5'h1F;
   // event numbers
   localparam logic [2:0]  LITC_EV_BASE  = 3'h0;
   localparam logic [2:0]  LITC_EV_CDC   = 3'h1;
   localparam logic [2:0]  LITC_EV_SND   = 3'h2;
   localparam logic [2:0]  LITC_EV_FM    = 3'h3;
   localparam logic [2:0]  LITC_EV_MINTC = 3'h4;
   localparam logic [2:0]  LITC_EV_MDMA  = 3'h5;
   localparam logic [2:0]  LITC_EV_SINTC = 3'h6;
   localparam logic [2:0]  LITC_EV_SDMA  = 3'h7;
   // decode windows, inclusive bounds
   localparam logic [15:0] LITC_BASE_LO0 = 16'h0320;
   localparam logic [15:0] LITC_BASE_SPAN = 16'h0007;
   localparam logic [15:0] LITC_BASE_STEP = 16'h0010;
   localparam logic [15:0] LITC_CDC_LO0  = 16'h0530;
   localparam logic [15:0] LITC_CDC_LO2  = 16'h0E80;
   localparam logic [15:0] LITC_CDC_LO3  = 16'h0F40;
   localparam logic [15:0] LITC_CDC_SPAN = 16'h0007;
   localparam logic [15:0] LITC_SND_LO0  = 16'h0220;
   localparam logic [15:0] LITC_SND_LO1  = 16'h0240;
   localparam logic [15:0] LITC_SND_SPAN = 16'h000F;
   localparam logic [15:0] LITC_FM_LO    = 16'h0388;
   localparam logic [15:0] LITC_FM_HI    = 16'h038B;
   localparam logic [15:0] LITC_MINTC_LO = 16'h0020;
   localparam logic [15:0] LITC_MINTC_HI = 16'h0021;
   localparam logic [15:0] LITC_MDMA_LO  = 16'h0000;
   localparam logic [15:0] LITC_MDMA_HI  = 16'h000F;
   localparam logic [15:0] LITC_SINTC_LO = 16'h00A0;
   localparam logic [15:0] LITC_SINTC_HI = 16'h00A1;
   localparam logic [15:0] LITC_SDMA_LO  = 16'h00C0;
   localparam logic [15:0] LITC_SDMA_HI  = 16'h00DF;
endpackage

// *** rtl/litc_trap_capture.sv ***
// Purpose: legacy host I/O trap capture with one control/status word
// Assumes: host I/O cycles and register accesses arrive on clk
// Notes:   read data is registered, one cycle after the read strobe
//
// Behaviour
// - one 32-bit word: control high, status low
// - bit 31 selects fast joystick timing
// - bit 30 blocks host irq, needs dma config
// - bit 29 picks sound register window
// - bits 28:27 pick base register window
// - bits 26:25 pick codec window, 01 none
// - bit 24 forces the legacy interrupt
// - bit 23 enables slave dma trap
// - bit 22 enables slave irq controller trap
// - bit 21 enables master dma trap
// - bit 20 enables master irq controller trap
// - bit 19 enables fm register trap
// - bits 18:16 enable sound, codec, base traps
// - bits 10:8 report the event number
// - bits 7:3 hold low address bits
// - bit 2 gives captured direction, one=write
// - bits 15:11 read ones, bit 1 zero
// - bit 0 flag active low, a write with byte lane 0 enabled clears
`timescale 1ns/1ns
module litc_trap_capture
   import litc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [5:0]  regAddr,
   input  wire logic        regRead,
   input  wire logic        regWrite,
   input  wire logic [3:0]  regByteEn,
   input  wire logic [31:0] regWdata,
   output logic      [31:0] regRdata,
   input  wire logic        ioValid,
   input  wire logic [15:0] ioAddr,
   input  wire logic        ioWrite,
   input  wire logic        dmaConfig,
   output logic             fastJoystick,
   output logic             hostIrqBlock,
   output logic             legacyIrq
);

   logic [15:0] ctrl_reg;     // control half, bits 31:16
   logic [2:0]  evId_reg;     // captured event number
   logic [4:0]  addrLow_reg;  // captured low address bits
   logic        dirWrite_reg; // captured direction
   logic        flag_reg;     // capture flag, active high inside
   logic        regHit;       // access aimed at our word
   logic        flagClear;    // host write to byte lane 0
   logic [7:0]  hitVec;       // per-event window hit, enable applied
   logic        anyHit;       // some enabled window hit
   logic [2:0]  hitId;        // winning event number
   logic        capture;      // latch this cycle
   logic [31:0] readWord;     // assembled read value

   // inclusive window test
   function automatic logic inWin(input logic [15:0] a, input logic [15:0] lo,
                                  input logic [15:0] hi);
      inWin = (a >= lo) && (a <= hi);
   endfunction

   // window decode for all eight sources, gated by their enables
   function automatic logic [7:0] decode(input logic [15:0] a, input logic [15:0] c);
      logic [15:0] baseLo;
      logic [15:0] sndLo;
      logic        cdcHit;
      baseLo = LITC_BASE_LO0 + LITC_BASE_STEP * {14'h0000, c[LITC_B_BASEHI-16],
                                                 c[LITC_B_BASELO-16]};
      sndLo  = c[LITC_B_SNDSEL-16] ? LITC_SND_LO1 : LITC_SND_LO0;
      // codec window, code 01 decodes nothing
      unique case ({c[LITC_B_CDCHI-16], c[LITC_B_CDCLO-16]})
         2'b00:   cdcHit = inWin(a, LITC_CDC_LO0, LITC_CDC_LO0 + LITC_CDC_SPAN);
         2'b10:   cdcHit = inWin(a, LITC_CDC_LO2, LITC_CDC_LO2 + LITC_CDC_SPAN);
         2'b11:   cdcHit = inWin(a, LITC_CDC_LO3, LITC_CDC_LO3 + LITC_CDC_SPAN);
         default: cdcHit = 1'b0;
      endcase
      decode[LITC_EV_BASE]  = c[LITC_B_BASE-16] &
                              inWin(a, baseLo, baseLo + LITC_BASE_SPAN);
      decode[LITC_EV_CDC]   = c[LITC_B_CDC-16] & cdcHit;
      decode[LITC_EV_SND]   = c[LITC_B_SND-16] & inWin(a, sndLo, sndLo + LITC_SND_SPAN);
      decode[LITC_EV_FM]    = c[LITC_B_FM-16] & inWin(a, LITC_FM_LO, LITC_FM_HI);
      decode[LITC_EV_MINTC] = c[LITC_B_MINTC-16] &
                              inWin(a, LITC_MINTC_LO, LITC_MINTC_HI);
      decode[LITC_EV_MDMA]  = c[LITC_B_MDMA-16] &
                              inWin(a, LITC_MDMA_LO, LITC_MDMA_HI);
      decode[LITC_EV_SINTC] = c[LITC_B_SINTC-16] &
                              inWin(a, LITC_SINTC_LO, LITC_SINTC_HI);
      decode[LITC_EV_SDMA]  = c[LITC_B_SDMA-16] &
                              inWin(a, LITC_SDMA_LO, LITC_SDMA_HI);
   endfunction

   // register select and flag clear strobe
   assign regHit    = (regAddr == LITC_OFS_CTRL_STAT);
   assign flagClear = regWrite & regHit & regByteEn[0];

   // window hits and lowest-number priority
   always_comb begin
      hitVec = ioValid ? decode(ioAddr, ctrl_reg) : 8'h00;
      hitId  = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (hitVec[i]) begin
            hitId = 3'(i);
         end
      end
   end
   assign anyHit = |hitVec;

   // capture only when no event is pending, or it is being cleared now
   assign capture = anyHit & (~flag_reg | flagClear);

   // control half, byte lanes 3 and 2 write, lane 1 holds read-only bits
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= LITC_CTRL_RST;
      end else if (regWrite && regHit) begin
         if (regByteEn[3]) begin
            ctrl_reg[15:8] <= regWdata[31:24];
         end
         if (regByteEn[2]) begin
            ctrl_reg[7:0] <= regWdata[23:16];
         end
      end
   end

   // captured event fields
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         evId_reg     <= 3'h0;
         addrLow_reg  <= 5'h00;
         dirWrite_reg <= 1'b0;
      end else if (capture) begin
         evId_reg     <= hitId;
         addrLow_reg  <= ioAddr[4:0];
         dirWrite_reg <= ioWrite;
      end
   end

   // capture flag, a new hit wins over a clear in the same cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flag_reg <= 1'b0;
      end else if (capture) begin
         flag_reg <= 1'b1;
      end else if (flagClear) begin
         flag_reg <= 1'b0;
      end
   end

   // read word: bit 0 is the active-low flag
   assign readWord = {ctrl_reg, LITC_ONES, evId_reg, addrLow_reg,
                      dirWrite_reg, 1'b0, ~flag_reg};

   // registered read data, zero for other offsets
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         regRdata <= 32'h00000000;
      end else if (regRead) begin
         regRdata <= regHit ? readWord : 32'h00000000;
      end
   end

   // control outputs
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fastJoystick <= 1'b0;
         hostIrqBlock <= 1'b0;
      end else begin
         fastJoystick <= ctrl_reg[LITC_B_FAST-16];
         hostIrqBlock <= ctrl_reg[LITC_B_HIB-16] & dmaConfig;
      end
   end

   // interrupt request toward the host
   assign legacyIrq = flag_reg | ctrl_reg[LITC_B_FORCE-16];

   // helper: write of a lane-3 byte
   sequence s_topWrite;
      regWrite && regHit && regByteEn[3];
   endsequence

   sequence s_capture;
      capture;
   endsequence

   // helper: write of a lane-2 byte
   sequence s_midWrite;
      regWrite && regHit && regByteEn[2];
   endsequence

   // helper: read strobe aimed at our word
   sequence s_readWord;
      regRead && regHit;
   endsequence

   a_read_fixed_bits: assert property (@(posedge clk) disable iff (rst)
      regRead && regHit |=> regRdata[15:11] == LITC_ONES && !regRdata[1])
      else $error("fixed bits wrong on read");

   a_fast_timing: assert property (@(posedge clk) disable iff (rst)
      s_topWrite |=> ##1 fastJoystick == $past(regWdata[31], 2))
      else $error("joystick timing not following bit 31");

   a_hib_gated: assert property (@(posedge clk) disable iff (rst)
      hostIrqBlock |-> $past(dmaConfig) && $past(ctrl_reg[LITC_B_HIB-16]))
      else $error("irq block without dma config");

   a_capture_flags: assert property (@(posedge clk) disable iff (rst)
      s_capture |=> flag_reg && legacyIrq)
      else $error("capture did not raise flag");

   a_status_held: assert property (@(posedge clk) disable iff (rst)
      flag_reg && !flagClear |=> $stable(evId_reg) && $stable(addrLow_reg)
                                 && $stable(dirWrite_reg))
      else $error("status changed while pending");

   a_flag_clear: assert property (@(posedge clk) disable iff (rst)
      flagClear && !anyHit |=> !flag_reg)
      else $error("write to bit 0 did not clear flag");

   a_addr_dir: assert property (@(posedge clk) disable iff (rst)
      s_capture |=> addrLow_reg == $past(ioAddr[4:0]) && dirWrite_reg == $past(ioWrite))
      else $error("address or direction not latched");

   a_event_base: assert property (@(posedge clk) disable iff (rst)
      (s_capture and hitVec[LITC_EV_BASE]) |=> evId_reg == LITC_EV_BASE)
      else $error("base event number wrong");

   a_force_irq: assert property (@(posedge clk) disable iff (rst)
      (s_topWrite and regWdata[LITC_B_FORCE]) ##1 !(regWrite && regHit && regByteEn[3])
      |-> legacyIrq [*2])
      else $error("forced interrupt missing");

   // control half: each lane lands, nothing else moves it
   a_lane3_write: assert property (@(posedge clk) disable iff (rst)
      s_topWrite |=> ctrl_reg[15:8] == $past(regWdata[31:24]))
      else $error("lane 3 write not taken");

   a_lane2_write: assert property (@(posedge clk) disable iff (rst)
      s_midWrite |=> ctrl_reg[7:0] == $past(regWdata[23:16]))
      else $error("lane 2 write not taken");

   a_ctrl_stable: assert property (@(posedge clk) disable iff (rst)
      !(regWrite && regHit) |=> $stable(ctrl_reg))
      else $error("control half changed without a write");

   // read word: status fields and the active-low flag
   a_read_status: assert property (@(posedge clk) disable iff (rst)
      s_readWord |=> regRdata[10:2] == {$past(evId_reg), $past(addrLow_reg),
                                        $past(dirWrite_reg)}
                     && regRdata[0] == !$past(flag_reg))
      else $error("status half read back wrong");

   a_read_ctrl: assert property (@(posedge clk) disable iff (rst)
      s_readWord |=> regRdata[31:16] == $past(ctrl_reg))
      else $error("control half read back wrong");

   // window decode: an enabled source inside its window must hit
   a_base_window: assert property (@(posedge clk) disable iff (rst)
      ioValid && ctrl_reg[LITC_B_BASE-16] && !ioAddr[3]
      && ioAddr[15:4] == LITC_BASE_LO0[15:4]
                         + {10'h000, ctrl_reg[LITC_B_BASEHI-16:LITC_B_BASELO-16]}
      |-> hitVec[LITC_EV_BASE])
      else $error("base window missed");

   a_sound_window: assert property (@(posedge clk) disable iff (rst)
      ioValid && ctrl_reg[LITC_B_SND-16]
      && ioAddr[15:4] == (ctrl_reg[LITC_B_SNDSEL-16] ? LITC_SND_LO1[15:4] : LITC_SND_LO0[15:4])
      |-> hitVec[LITC_EV_SND])
      else $error("sound window missed");

   a_codec_none: assert property (@(posedge clk) disable iff (rst)
      ctrl_reg[LITC_B_CDCHI-16:LITC_B_CDCLO-16] == 2'b01 |-> !hitVec[LITC_EV_CDC])
      else $error("codec hit with undefined window code");

   a_codec_window: assert property (@(posedge clk) disable iff (rst)
      ioValid && ctrl_reg[LITC_B_CDC-16] && ctrl_reg[LITC_B_CDCHI-16]
      && ioAddr[15:3] == (ctrl_reg[LITC_B_CDCLO-16] ? LITC_CDC_LO3[15:3] : LITC_CDC_LO2[15:3])
      |-> hitVec[LITC_EV_CDC])
      else $error("codec window missed");

   a_fm_window: assert property (@(posedge clk) disable iff (rst)
      ioValid && ctrl_reg[LITC_B_FM-16] && ioAddr[15:2] == LITC_FM_LO[15:2]
      |-> hitVec[LITC_EV_FM])
      else $error("fm window missed");

   a_mintc_window: assert property (@(posedge clk) disable iff (rst)
      ioValid && ctrl_reg[LITC_B_MINTC-16] && ioAddr[15:1] == LITC_MINTC_LO[15:1]
      |-> hitVec[LITC_EV_MINTC])
      else $error("master irq controller window missed");

   a_sintc_window: assert property (@(posedge clk) disable iff (rst)
      ioValid && ctrl_reg[LITC_B_SINTC-16] && ioAddr[15:1] == LITC_SINTC_LO[15:1]
      |-> hitVec[LITC_EV_SINTC])
      else $error("slave irq controller window missed");

   a_mdma_window: assert property (@(posedge clk) disable iff (rst)
      ioValid && ctrl_reg[LITC_B_MDMA-16] && ioAddr[15:4] == LITC_MDMA_LO[15:4]
      |-> hitVec[LITC_EV_MDMA])
      else $error("master dma window missed");

   a_sdma_window: assert property (@(posedge clk) disable iff (rst)
      ioValid && ctrl_reg[LITC_B_SDMA-16] && ioAddr[15:5] == LITC_SDMA_LO[15:5]
      |-> hitVec[LITC_EV_SDMA])
      else $error("slave dma window missed");

   // enable bit n of the control half belongs to event n, so clear means no hit
   for (genvar g = 0; g < 8; g++) begin : g_gate
      a_trap_gated: assert property (@(posedge clk) disable iff (rst)
         !ctrl_reg[g] |-> !hitVec[g])
         else $error("disabled source hit");
   end

   a_idle_quiet: assert property (@(posedge clk) disable iff (rst)
      !ioValid |-> !anyHit)
      else $error("hit without a host cycle");

   a_hib_needs_dma: assert property (@(posedge clk) disable iff (rst)
      !dmaConfig |=> !hostIrqBlock)
      else $error("irq block while dma config clear");

endmodule

// *** verification/litc_host_model.sv ***
// Purpose: host side model issuing legacy I/O cycles
// Assumes: one cycle per call, launched at a rising edge
// Notes:   released lines show the inverted last value
`timescale 1ns/1ns
module litc_host_model (
   input  wire logic        clk,
   output logic             ioValid,
   output logic      [15:0] ioAddr,
   output logic             ioWrite
);
   // idle at time zero
   initial begin
      ioValid = 1'b0;
      ioAddr  = 16'hFFFF;
      ioWrite = 1'b0;
   end
   // one-cycle pulse, then lines released to inverse
   task automatic hit(input logic [15:0] a, input logic w);
      @(posedge clk);
      ioValid <= 1'b1;
      ioAddr  <= a;
      ioWrite <= w;
      @(posedge clk);
      ioValid <= 1'b0;
      ioAddr  <= ~a;
      ioWrite <= ~w;
   endtask
endmodule

// *** verification/testbench.sv ***
// Purpose: self-checking bench for the trap capture block
// Assumes: registered read data, one cycle after the strobe
// Notes:   every scenario is a task that judges its own results
`timescale 1ns/1ns
module testbench
   import litc_pkg::*;
;
   logic clk, rst, regRead, regWrite, ioValid, ioWrite, dmaConfig;
   logic fastJoystick, hostIrqBlock, legacyIrq;
   logic [5:0]  regAddr;
   logic [3:0]  regByteEn;
   logic [31:0] regWdata, regRdata;
   logic [15:0] ioAddr;
   int          n_errors, checks, cycles;
   // window table: control half, address, event number
   logic [15:0] tCtrl [11] = '{16'h0001, 16'h1801, 16'h0002, 16'h0402, 16'h0602,
      16'h2004, 16'h0008, 16'h0010, 16'h0020, 16'h0040, 16'h0080};
   logic [15:0] tAddr [11] = '{16'h0327, 16'h0350, 16'h0533, 16'h0E87, 16'h0F40,
      16'h024F, 16'h038B, 16'h0021, 16'h000F, 16'h00A0, 16'h00DF};
   logic [2:0]  tEv [11] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4,
      3'h5, 3'h6, 3'h7};
   litc_trap_capture dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regRead(regRead),
      .regWrite(regWrite), .regByteEn(regByteEn), .regWdata(regWdata),
      .regRdata(regRdata), .ioValid(ioValid), .ioAddr(ioAddr), .ioWrite(ioWrite),
      .dmaConfig(dmaConfig), .fastJoystick(fastJoystick),
      .hostIrqBlock(hostIrqBlock), .legacyIrq(legacyIrq));
   litc_host_model host (.clk(clk), .ioValid(ioValid), .ioAddr(ioAddr),
      .ioWrite(ioWrite));
   // free-running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // register write at the block offset, one-cycle strobe
   task automatic wr(input logic [31:0] d, input logic [3:0] be);
      @(posedge clk);
      regAddr   <= LITC_OFS_CTRL_STAT;
      regWrite  <= 1'b1;
      regByteEn <= be;
      regWdata  <= d;
      @(posedge clk);
      regWrite  <= 1'b0;
   endtask
   // register read, data sampled once the load edge settled
   task automatic rd(input logic [5:0] a, output logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1 d = regRdata;
   endtask
   task automatic test_control();
      logic [31:0] d;
      rd(LITC_OFS_CTRL_STAT, d);
      chk("reset word", 32'h0000F801, d);
      wr(32'h0000FFFE, 4'h2);
      rd(LITC_OFS_CTRL_STAT, d);
      chk("lane 1 ignored", 32'h0000F801, d);
      wr(32'hC1FF07FE, 4'h8);
      rd(LITC_OFS_CTRL_STAT, d);
      chk("control word", 32'hC100F801, d);
      chk("fast timing", 1, fastJoystick);
      chk("irq block off", 0, hostIrqBlock);
      chk("forced irq", 1, legacyIrq);
      @(posedge clk);
      dmaConfig <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk("irq block on", 1, hostIrqBlock);
      wr(32'h0, 4'h8);
      dmaConfig <= 1'b0;
      rd(6'h1C, d);
      chk("unmapped read", 0, d);
      chk("force released", 0, legacyIrq);
      chk("slow timing", 0, fastJoystick);
      chk("irq block cleared", 0, hostIrqBlock);
   endtask
   task automatic test_hold();
      logic [31:0] d;
      wr(32'h00040000, 4'h4);
      host.hit(16'h0225, 1'b1);
      rd(LITC_OFS_CTRL_STAT, d);
      chk("sound trap", 32'h0004FA2C, d);
      chk("trap irq", 1, legacyIrq);
      host.hit(16'h022A, 1'b0);
      rd(LITC_OFS_CTRL_STAT, d);
      chk("held status", 32'h0004FA2C, d);
      wr(32'h00000001, 4'h1);
      rd(LITC_OFS_CTRL_STAT, d);
      chk("cleared flag", 32'h00040001, {d[31:16], 15'h0, d[0]});
      chk("irq quiet", 0, legacyIrq);
   endtask
   task automatic test_windows();
      logic [31:0] d;
      for (int i = 0; i < 11; i++) begin
         wr({tCtrl[i], 16'h0000}, 4'hC);
         host.hit(tAddr[i], i[0]);
         rd(LITC_OFS_CTRL_STAT, d);
         chk("trap word", {tCtrl[i], 5'h1F, tEv[i], tAddr[i][4:0], i[0], 2'b00}, d);
         wr(32'h0, 4'h1);
      end
   endtask
   task automatic test_misses();
      logic [31:0] d;
      wr(32'h1A7F0000, 4'hC);
      host.hit(16'h00C0, 1'b1);
      host.hit(16'h0347, 1'b0);
      host.hit(16'h0530, 1'b1);
      rd(LITC_OFS_CTRL_STAT, d);
      chk("no capture", 32'h1A7FF801, {d[31:11], 10'h0, d[0]});
      chk("no irq", 0, legacyIrq);
   endtask
   // reset, then the scenarios in turn
   initial begin
      rst = 1'b1;
      regAddr = 6'h00;
      regRead = 1'b0;
      regWrite = 1'b0;
      regByteEn = 4'h0;
      regWdata = 32'h0;
      dmaConfig = 1'b0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      test_control();
      test_hold();
      test_windows();
      test_misses();
      report_and_stop();
   end
endmodule
